// ---- logic/ep_fifo_pkg.sv ----
package ep_fifo_pkg;
   // register map of the endpoint buffer port, byte addresses on its processor bus
   localparam logic [9:0]  MAXPKT_OFS       = 10'h204;
   localparam logic [9:0]  EPTYPE_OFS       = 10'h208;
   localparam logic [9:0]  PKT_LEN_OFS      = 10'h21c;
   localparam logic [9:0]  FIFO_WIN_OFS     = 10'h220;
   localparam logic [9:0]  CTRL_OFS         = 10'h228;
   localparam logic [9:0]  INDEX_OFS        = 10'h22c;
   localparam logic [9:0]  EPSTAT_OFS       = 10'h230;
   localparam int          CTRL_STALL_BIT   = 0;
   localparam int          CTRL_STATUS_BIT  = 1;
   localparam int          CTRL_VALID_BIT   = 3;
   localparam int          CTRL_CLEAR_BIT   = 4;
   localparam logic [1:0]  EPTYPE_ISO       = 2'h1;
   localparam logic [15:0] PKT_LEN_RESET    = 16'h0000;
   localparam logic [31:0] FIFO_WIN_RESET   = 32'h0000_0000;
   localparam logic [10:0] FSIZE_RESET      = 11'h000;
   // controller registers on apb
   localparam logic [7:0]  APB_CMD_OFS      = 8'h00;
   localparam logic [7:0]  APB_WDATA_OFS    = 8'h04;
   localparam logic [7:0]  APB_RDATA_OFS    = 8'h08;
   localparam logic [7:0]  APB_STATUS_OFS   = 8'h0c;
   localparam logic [7:0]  APB_CFG_OFS      = 8'h10;
   localparam int          CMD_WRITE_BIT    = 31;
   localparam int          CFG_MODE32_BIT   = 0;
   localparam int          CFG_DMA_BIT      = 1;
   localparam logic [31:0] APB_RESET        = 32'h0000_0000;
   // timing
   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          READ_HOLDOFF_NS  = 500;
   localparam int          READ_HOLDOFF_CYC = (READ_HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      RESP_NONE  = 3'h0,
      RESP_ACK   = 3'h1,
      RESP_NAK   = 3'h3,
      RESP_STALL = 3'h2,
      RESP_DATA  = 3'h6,
      RESP_ZLP   = 3'h7
   } resp_t;

   typedef enum logic [1:0] {
      CST_IDLE  = 2'h0,
      CST_HOLD  = 2'h1,
      CST_ISSUE = 2'h3,
      CST_WAIT  = 2'h2
   } ctrl_state_t;
endpackage

// ---- logic/ep_bus_if.sv ----
`timescale 1ns/10ps
interface ep_bus_if (
   input wire logic pclk,
   input wire logic presetn
);
   logic        req;
   logic        wr;
   logic [9:0]  addr;
   logic [31:0] wdata;
   logic        mode32;
   logic        dma_mode;
   logic [31:0] rdata;
   logic        ack;
   logic        ep_event;

   modport device (
      input  pclk, presetn, req, wr, addr, wdata, mode32, dma_mode,
      output rdata, ack, ep_event
   );
   modport ctrl (
      output req, wr, addr, wdata, mode32, dma_mode,
      input  rdata, ack, ep_event
   );
endinterface

// ---- logic/ep_word_ram.sv ----
`timescale 1ns/10ps
module ep_word_ram #(
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   // clock
   input  wire logic          pclk,
   // write port with byte lanes
   input  wire logic          we,
   input  wire logic [3:0]    be,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [31:0]   wdata,
   // read port
   input  wire logic [AW-1:0] raddr,
   output logic [31:0]        rdata
);
   if (DEPTH < 1 || (1 << AW) < DEPTH) begin : bad_cfg
      $error("ep_word_ram: AW too narrow for DEPTH");
   end

   logic [31:0] mem [DEPTH];
   logic [31:0] next_word;

   always_comb begin
      next_word = mem[waddr];
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            next_word[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
   end

   // payload storage needs no reset; valid state lives in the endpoint logic
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= next_word;
      end
   end

   assign rdata = mem[raddr];
endmodule

// ---- logic/ep_fifo_device.sv ----
// Contract
// - status bit clears after status packet acknowledged
// - firmware finishes data stage before status bit
// - stall bit stalls endpoint, never isochronous ones
// - firmware toggles enable after stall for toggle
// - in-endpoint write advances pointer two or four
// - full max-packet count validates in buffer
// - validate bit readies short in buffer
// - out-endpoint read moves pointer two or four
// - fully read out buffer clears itself
// - clear bit discards indexed receive buffer
// - data window at its address, resets zero
// - firmware waits 500 ns before first read
// - max-packet write loads length with size
// - usb bus reset zeroes packet length
// - short length written first, then auto-validate
// - short auto-validate only for programmed io
// - acked out packet loads length with count
// - odd final byte in low lane, 16-bit
// - 16-bit read/write packet length at address
// - data window reaches only indexed endpoint
// - status stage: zero nak, one zlp/ack
`timescale 1ns/10ps
module ep_fifo_device
   import ep_fifo_pkg::*;
#(
   parameter int NUM_EP = 4,
   parameter int DEPTH  = 16
) (
   // processor side
   ep_bus_if.device              bus,
   // usb token side
   input  wire logic                      usb_bus_reset,
   input  wire logic [$clog2(NUM_EP)-1:0] tok_ep,
   input  wire logic                      in_token,
   input  wire logic                      out_token,
   input  wire logic                      status_token,
   input  wire logic                      status_dir_in,
   input  wire logic                      in_ack,
   input  wire logic [15:0]               out_len,
   // usb payload side
   input  wire logic                      usb_we,
   input  wire logic [$clog2(DEPTH)-1:0]  usb_widx,
   input  wire logic [31:0]               usb_wdata,
   input  wire logic [$clog2(DEPTH)-1:0]  usb_ridx,
   output logic [31:0]                    usb_rdata,
   // token answer
   output resp_t                          resp,
   output logic                           resp_valid,
   output logic [15:0]                    resp_len
);
   localparam int EW = $clog2(NUM_EP);
   localparam int AW = $clog2(DEPTH);

   if (NUM_EP < 2 || DEPTH < 2 || (1 << AW) != DEPTH) begin : bad_cfg
      $error("ep_fifo_device: NUM_EP and DEPTH must be at least 2, DEPTH a power of two");
   end

   // odd endpoints are in (device to host), even ones out; endpoint 0 is control
   logic [EW-1:0]     idx,        next_idx;
   logic [15:0]       pkt_len     [NUM_EP];
   logic [15:0]       next_pkt_len[NUM_EP];
   logic [15:0]       ptr         [NUM_EP];
   logic [15:0]       next_ptr    [NUM_EP];
   logic [10:0]       fsize       [NUM_EP];
   logic [10:0]       next_fsize  [NUM_EP];
   logic [NUM_EP-1:0] iso,        next_iso;
   logic [NUM_EP-1:0] valid,      next_valid;
   logic [NUM_EP-1:0] full,       next_full;
   logic [NUM_EP-1:0] stall,      next_stall;
   logic              status_ack, next_status_ack;
   logic [31:0]       rdata,      next_rdata;
   logic              ep_event,   next_ep_event;
   resp_t             next_resp;
   logic              next_resp_valid;
   logic [15:0]       next_resp_len;
   logic [31:0]       next_usb_rdata;

   logic              cpu_we;
   logic [3:0]        cpu_be;
   logic [31:0]       cpu_wlanes;
   logic [15:0]       step;
   logic [15:0]       target;
   logic [15:0]       rd_off;
   logic [31:0]       rd_word [NUM_EP];
   logic [31:0]       rd_sel;

   assign step       = bus.mode32 ? 16'h0004 : 16'h0002;
   assign cpu_be     = bus.mode32 ? 4'hf : (ptr[idx][1] ? 4'hc : 4'h3);
   assign cpu_wlanes = bus.mode32 ? bus.wdata : {2{bus.wdata[15:0]}};
   assign rd_off     = pkt_len[idx] - ptr[idx];
   assign rd_sel     = rd_word[idx];

   // short-length trigger only counts under programmed io
   always_comb begin
      if (!bus.dma_mode && pkt_len[idx] != 16'h0000 && pkt_len[idx] < {5'h00, fsize[idx]}) begin
         target = pkt_len[idx];
      end else begin
         target = {5'h00, fsize[idx]};
      end
   end

   for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
      logic          we_e;
      logic [3:0]    be_e;
      logic [AW-1:0] wa_e;
      logic [31:0]   wd_e;
      logic [AW-1:0] ra_e;
      if (e % 2 == 1) begin : g_in
         assign we_e = cpu_we && idx == EW'(e);
         assign be_e = cpu_be;
         assign wa_e = ptr[e][AW+1:2];
         assign wd_e = cpu_wlanes;
         assign ra_e = usb_ridx;
      end else begin : g_out
         // a full receive buffer refuses new payload until firmware drains it
         assign we_e = usb_we && tok_ep == EW'(e) && !full[e];
         assign be_e = 4'hf;
         assign wa_e = usb_widx;
         assign wd_e = usb_wdata;
         assign ra_e = AW'((pkt_len[e] - ptr[e]) >> 2);
      end
      ep_word_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
         .pclk  (bus.pclk),
         .we    (we_e),
         .be    (be_e),
         .waddr (wa_e),
         .wdata (wd_e),
         .raddr (ra_e),
         .rdata (rd_word[e])
      );
   end

   always_comb begin
      next_idx        = idx;
      next_pkt_len    = pkt_len;
      next_ptr        = ptr;
      next_fsize      = fsize;
      next_iso        = iso;
      next_valid      = valid;
      next_full       = full;
      next_stall      = stall;
      next_status_ack = status_ack;
      next_rdata      = rdata;
      next_ep_event   = 1'b0;
      next_resp       = RESP_NONE;
      next_resp_valid = 1'b0;
      next_resp_len   = 16'h0000;
      next_usb_rdata  = rd_word[tok_ep];
      cpu_we          = 1'b0;

      if (bus.req) begin
         next_rdata = 32'h0000_0000;
         if (bus.addr == INDEX_OFS) begin
            if (bus.wr) next_idx = bus.wdata[EW-1:0];
            next_rdata = 32'(idx);
         end else if (bus.addr == MAXPKT_OFS) begin
            if (bus.wr) begin
               next_fsize[idx]   = bus.wdata[10:0];
               next_pkt_len[idx] = {5'h00, bus.wdata[10:0]};
            end
            next_rdata = 32'(fsize[idx]);
         end else if (bus.addr == EPTYPE_OFS) begin
            if (bus.wr) next_iso[idx] = bus.wdata[1:0] == EPTYPE_ISO;
            next_rdata = {30'h0000_0000, iso[idx], 1'b0};
         end else if (bus.addr == PKT_LEN_OFS) begin
            if (bus.wr) next_pkt_len[idx] = bus.wdata[15:0];
            next_rdata = {16'h0000, pkt_len[idx]};
         end else if (bus.addr == FIFO_WIN_OFS) begin
            if (idx[0]) begin
               // writes into a queued buffer are dropped so the packet on the wire stays intact
               if (bus.wr && !valid[idx]) begin
                  cpu_we        = 1'b1;
                  next_ptr[idx] = ptr[idx] + step;
                  if (ptr[idx] + step >= target) next_valid[idx] = 1'b1;
               end
            end else if (!bus.wr && full[idx]) begin
               if (bus.mode32) begin
                  next_rdata = rd_sel;
               end else begin
                  next_rdata = {16'h0000, rd_off[1] ? rd_sel[31:16] : rd_sel[15:0]};
               end
               if (ptr[idx] == 16'h0001) next_rdata[31:8] = 24'h00_0000;
               if (ptr[idx] <= step) begin
                  next_ptr[idx]  = 16'h0000;
                  next_full[idx] = 1'b0;
               end else begin
                  next_ptr[idx] = ptr[idx] - step;
               end
            end
         end else if (bus.addr == CTRL_OFS) begin
            if (bus.wr) begin
               if (!iso[idx]) next_stall[idx] = bus.wdata[CTRL_STALL_BIT];
               if (bus.wdata[CTRL_VALID_BIT] && idx[0]) next_valid[idx] = 1'b1;
               if (bus.wdata[CTRL_CLEAR_BIT] && !idx[0]) begin
                  next_full[idx] = 1'b0;
                  next_ptr[idx]  = 16'h0000;
               end
            end
            next_rdata = {30'h0000_0000, status_ack, stall[idx]};
         end else if (bus.addr == EPSTAT_OFS) begin
            next_rdata = {30'h0000_0000, full[idx], valid[idx]};
         end
      end

      // usb events follow the bus so a hardware set wins over a same-cycle clear
      if (usb_bus_reset) begin
         for (int e = 0; e < NUM_EP; e++) begin
            next_pkt_len[e] = PKT_LEN_RESET;
            next_ptr[e]     = 16'h0000;
         end
         next_valid      = '0;
         next_full       = '0;
         next_stall      = '0;
         next_status_ack = 1'b0;
      end else if (status_token) begin
         next_resp_valid = 1'b1;
         if (!status_ack) begin
            next_resp = RESP_NAK;
         end else if (status_dir_in) begin
            next_resp = RESP_ZLP;
         end else begin
            next_resp       = RESP_ACK;
            next_status_ack = 1'b0;
         end
      end else if (out_token) begin
         next_resp_valid = 1'b1;
         if (stall[tok_ep]) begin
            next_resp = RESP_STALL;
         end else if (full[tok_ep] || tok_ep[0]) begin
            next_resp = RESP_NAK;
         end else begin
            next_resp            = RESP_ACK;
            next_full[tok_ep]    = 1'b1;
            next_pkt_len[tok_ep] = out_len;
            next_ptr[tok_ep]     = out_len;
            next_ep_event        = 1'b1;
         end
      end else if (in_token) begin
         next_resp_valid = 1'b1;
         if (stall[tok_ep]) begin
            next_resp = RESP_STALL;
         end else if (valid[tok_ep]) begin
            next_resp     = RESP_DATA;
            next_resp_len = ptr[tok_ep];
         end else begin
            next_resp = RESP_NAK;
         end
      end else if (in_ack) begin
         if (tok_ep == '0) begin
            next_status_ack = 1'b0;
         end else begin
            next_valid[tok_ep] = 1'b0;
            next_ptr[tok_ep]   = 16'h0000;
            next_ep_event      = 1'b1;
         end
      end

      if (bus.req && bus.wr && bus.addr == CTRL_OFS && bus.wdata[CTRL_STATUS_BIT]) begin
         next_status_ack = 1'b1;
      end
   end

   always_ff @(posedge bus.pclk or negedge bus.presetn) begin
      if (!bus.presetn) begin
         idx        <= '0;
         for (int e = 0; e < NUM_EP; e++) begin
            pkt_len[e] <= PKT_LEN_RESET;
            ptr[e]     <= 16'h0000;
            fsize[e]   <= FSIZE_RESET;
         end
         iso        <= '0;
         valid      <= '0;
         full       <= '0;
         stall      <= '0;
         status_ack <= 1'b0;
         rdata      <= FIFO_WIN_RESET;
         bus.ack    <= 1'b0;
         ep_event   <= 1'b0;
         resp       <= RESP_NONE;
         resp_valid <= 1'b0;
         resp_len   <= 16'h0000;
         usb_rdata  <= 32'h0000_0000;
      end else begin
         idx        <= next_idx;
         pkt_len    <= next_pkt_len;
         ptr        <= next_ptr;
         fsize      <= next_fsize;
         iso        <= next_iso;
         valid      <= next_valid;
         full       <= next_full;
         stall      <= next_stall;
         status_ack <= next_status_ack;
         rdata      <= next_rdata;
         bus.ack    <= bus.req;
         ep_event   <= next_ep_event;
         resp       <= next_resp;
         resp_valid <= next_resp_valid;
         resp_len   <= next_resp_len;
         usb_rdata  <= next_usb_rdata;
      end
   end

   assign bus.rdata    = rdata;
   assign bus.ep_event = ep_event;
endmodule

// ---- logic/ep_fifo_ctrl.sv ----
`timescale 1ns/10ps
module ep_fifo_ctrl
   import ep_fifo_pkg::*;
#(
   parameter int HOLDOFF_CYC = READ_HOLDOFF_CYC
) (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // endpoint buffer port
   ep_bus_if.ctrl           bus
);
   if (HOLDOFF_CYC < 1 || HOLDOFF_CYC > 65535) begin : bad_cfg
      $error("ep_fifo_ctrl: HOLDOFF_CYC out of range");
   end

   ctrl_state_t state,    next_state;
   logic [1:0]  cfg,      next_cfg;
   logic [31:0] cmd,      next_cmd;
   logic [31:0] wbuf,     next_wbuf;
   logic [31:0] rbuf,     next_rbuf;
   logic [15:0] hold,     next_hold;
   logic [31:0] rd_q,     next_rd_q;
   logic        err_q,    next_err_q;
   logic        setup;
   logic        commit;
   logic        mapped;
   logic        busy;

   assign setup  = psel && !penable;
   assign commit = psel && penable && !err_q;
   assign busy   = state != CST_IDLE;
   assign mapped = paddr == APB_CMD_OFS || paddr == APB_WDATA_OFS || paddr == APB_RDATA_OFS ||
                   paddr == APB_STATUS_OFS || paddr == APB_CFG_OFS;

   always_comb begin
      next_state = state;
      next_cfg   = cfg;
      next_cmd   = cmd;
      next_wbuf  = wbuf;
      next_rbuf  = rbuf;
      next_rd_q  = rd_q;
      next_err_q = err_q;
      next_hold  = (hold != 16'h0000) ? hold - 16'h0001 : hold;
      if (bus.ep_event) next_hold = 16'(HOLDOFF_CYC);

      // decode and read data are caught in setup, so every access completes in its first access cycle
      if (setup) begin
         next_err_q = !mapped || (pwrite && busy && paddr != APB_CFG_OFS);
         next_rd_q  = 32'h0000_0000;
         if (paddr == APB_CMD_OFS) begin
            next_rd_q = cmd;
         end else if (paddr == APB_WDATA_OFS) begin
            next_rd_q = wbuf;
         end else if (paddr == APB_RDATA_OFS) begin
            next_rd_q = rbuf;
         end else if (paddr == APB_STATUS_OFS) begin
            next_rd_q = {30'h0000_0000, hold != 16'h0000, busy};
         end else if (paddr == APB_CFG_OFS) begin
            next_rd_q = {30'h0000_0000, cfg};
         end
      end

      if (commit && pwrite) begin
         if (paddr == APB_CMD_OFS) begin
            next_cmd   = pwdata;
            next_state = CST_HOLD;
         end else if (paddr == APB_WDATA_OFS) begin
            next_wbuf = pwdata;
         end else if (paddr == APB_CFG_OFS) begin
            next_cfg = pwdata[1:0];
         end
      end

      case (state)
         CST_HOLD: begin
            // data window reads wait out the settle time after an endpoint event
            if (cmd[CMD_WRITE_BIT] || cmd[9:0] != FIFO_WIN_OFS || hold == 16'h0000) begin
               next_state = CST_ISSUE;
            end
         end
         CST_ISSUE: begin
            next_state = CST_WAIT;
         end
         CST_WAIT: begin
            if (bus.ack) begin
               next_rbuf  = bus.rdata;
               next_state = CST_IDLE;
            end
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= CST_IDLE;
         cfg   <= 2'h0;
         cmd   <= APB_RESET;
         wbuf  <= APB_RESET;
         rbuf  <= APB_RESET;
         rd_q  <= APB_RESET;
         err_q <= 1'b0;
         hold  <= 16'h0000;
      end else begin
         state <= next_state;
         cfg   <= next_cfg;
         cmd   <= next_cmd;
         wbuf  <= next_wbuf;
         rbuf  <= next_rbuf;
         rd_q  <= next_rd_q;
         err_q <= next_err_q;
         hold  <= next_hold;
      end
   end

   assign prdata       = rd_q;
   assign pready       = 1'b1;
   assign pslverr      = psel && penable && err_q;
   assign bus.req      = state == CST_ISSUE;
   assign bus.wr       = cmd[CMD_WRITE_BIT];
   assign bus.addr     = cmd[9:0];
   assign bus.wdata    = wbuf;
   assign bus.mode32   = cfg[CFG_MODE32_BIT];
   assign bus.dma_mode = cfg[CFG_DMA_BIT];
endmodule

// ---- sim/ep_fifo_port_props.sv ----
`timescale 1ns/10ps
module ep_fifo_port_props
   import ep_fifo_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // request side
   input wire logic        req,
   input wire logic        wr,
   input wire logic [9:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        mode32,
   input wire logic        dma_mode,
   // answer side
   input wire logic [31:0] rdata,
   input wire logic        ack,
   input wire logic        ep_event
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire rd_req = req && !wr;

   AST_ACK_NEXT: assert property (req |=> ack)
      else $error("no ack one cycle after request");
   AST_ACK_CAUSE: assert property (ack |-> $past(req))
      else $error("ack without a request");
   AST_REQ_SINGLE: assert property (req |=> !req [*2])
      else $error("request issued before previous access finished");
   AST_RDATA_HOLD: assert property (!req |=> $stable(rdata))
      else $error("read data changed without a request");
   AST_RDATA_RESET: assert property ($rose(presetn) |-> rdata == FIFO_WIN_RESET && !ack)
      else $error("read data not zero out of reset");
   AST_LEN_WIDTH: assert property (rd_req && addr == PKT_LEN_OFS |=> rdata[31:16] == 16'h0000)
      else $error("packet length wider than 16 bits");
   AST_WIN16: assert property (rd_req && !mode32 && addr == FIFO_WIN_OFS |=> rdata[31:16] == 16'h0000)
      else $error("upper lanes driven in 16-bit mode");
   AST_UNMAPPED: assert property (rd_req && addr == 10'h3fc |=> rdata == 32'h0000_0000)
      else $error("unmapped address read not zero");

   cover property (req && wr && addr == FIFO_WIN_OFS);
   cover property (rd_req && !mode32 && addr == FIFO_WIN_OFS);
   cover property (ep_event);
   cover property (req && dma_mode);
endmodule

// ---- sim/usb_endpoint_fifo_port_test.sv ----
`timescale 1ns/10ps
module usb_endpoint_fifo_port_test;
   import ep_fifo_pkg::*;
   localparam logic [4:0] K_IN = 5'h01, K_OUT = 5'h02, K_SOUT = 5'h04, K_SIN = 5'h0c, K_ACK = 5'h10;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, len, evt;
   logic        usb_bus_reset, in_token, out_token, status_token, status_dir_in, in_ack, usb_we, perr;
   logic [1:0]  tok_ep;
   logic [15:0] out_len, resp_len;
   logic [3:0]  usb_widx, usb_ridx;
   logic [31:0] usb_wdata, usb_rdata;
   resp_t       resp;
   logic        resp_valid;
   int          error_cnt, n_checks, cyc;

   ep_bus_if ep_bus_if_i (.pclk(pclk), .presetn(presetn));
   ep_fifo_ctrl #(.HOLDOFF_CYC(3)) ep_fifo_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus(ep_bus_if_i.ctrl));
   ep_fifo_device #(.NUM_EP(4), .DEPTH(16)) ep_fifo_device_i (.bus(ep_bus_if_i.device),
      .usb_bus_reset(usb_bus_reset), .tok_ep(tok_ep), .in_token(in_token), .out_token(out_token),
      .status_token(status_token), .status_dir_in(status_dir_in), .in_ack(in_ack), .out_len(out_len),
      .usb_we(usb_we), .usb_widx(usb_widx), .usb_wdata(usb_wdata), .usb_ridx(usb_ridx),
      .usb_rdata(usb_rdata), .resp(resp), .resp_valid(resp_valid), .resp_len(resp_len));
   ep_fifo_port_props ep_fifo_port_props_i (.pclk(pclk), .presetn(presetn), .req(ep_bus_if_i.req),
      .wr(ep_bus_if_i.wr), .addr(ep_bus_if_i.addr), .wdata(ep_bus_if_i.wdata),
      .mode32(ep_bus_if_i.mode32), .dma_mode(ep_bus_if_i.dma_mode), .rdata(ep_bus_if_i.rdata),
      .ack(ep_bus_if_i.ack), .ep_event(ep_bus_if_i.ep_event));

   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   // entered right after a clock edge; request held until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // device register access through the command registers; a read compares with d
   task automatic dev(input logic w, input logic [9:0] a, input logic [31:0] d);
      apb(1'b1, APB_WDATA_OFS, d);
      apb(1'b1, APB_CMD_OFS, {w, 21'h0, a});
      do apb(1'b0, APB_STATUS_OFS, 32'h0); while (rd[1:0] !== 2'b00);
      if (!w) begin
         apb(1'b0, APB_RDATA_OFS, 32'h0);
         chk(d, rd);
      end
   endtask

   task automatic tok(input logic [1:0] ep, input logic [4:0] k, input logic [15:0] n, input resp_t e);
      tok_ep <= ep;
      out_len <= n;
      {in_ack, status_dir_in, status_token, out_token, in_token} <= k;
      @(posedge pclk);
      {in_ack, status_dir_in, status_token, out_token, in_token} <= 5'h00;
      @(posedge pclk);
      len = {16'h0000, resp_len};
      evt = {31'h0, ep_bus_if_i.ep_event};
      if (k != K_ACK)
         chk({29'h0, e}, {29'h0, resp});
      chk({31'h0, k != K_ACK}, {31'h0, resp_valid});
   endtask

   task automatic pw(input logic [1:0] ep, input logic [3:0] ix, input logic [31:0] d);
      tok_ep <= ep;
      usb_we <= 1'b1;
      usb_widx <= ix;
      usb_wdata <= d;
      @(posedge pclk);
      usb_we <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rdw(input logic [1:0] ep, input logic [3:0] ix, input logic [31:0] e);
      tok_ep <= ep;
      usb_ridx <= ix;
      @(posedge pclk);
      @(posedge pclk);
      chk(e, usb_rdata);
   endtask

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict;
      end
   end

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {usb_bus_reset, tok_ep, in_token, out_token, status_token, status_dir_in, in_ack, out_len} = '0;
      {usb_we, usb_widx, usb_wdata, usb_ridx} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      dev(0, PKT_LEN_OFS, {16'h0000, PKT_LEN_RESET});
      dev(0, FIFO_WIN_OFS, FIFO_WIN_RESET);
      dev(0, 10'h3fc, 32'h0000_0000);
      apb(0, 8'h40, 32'h0);
      chk(32'h0000_0001, {31'h0, perr});
      // in endpoint 1 on a 32-bit bus
      apb(1, APB_CFG_OFS, 32'h0000_0001);
      dev(1, INDEX_OFS, 32'h0000_0001);
      dev(1, MAXPKT_OFS, 32'h0000_0008);
      dev(0, PKT_LEN_OFS, 32'h0000_0008);
      dev(1, FIFO_WIN_OFS, 32'h1111_0001);
      tok(1, K_IN, 0, RESP_NAK);
      dev(1, FIFO_WIN_OFS, 32'h2222_0002);
      tok(1, K_IN, 0, RESP_DATA);
      chk(32'h0000_0008, len);
      rdw(1, 1, 32'h2222_0002);
      tok(1, K_ACK, 0, RESP_NONE);
      // short packet under dma is left for the validate bit
      apb(1, APB_CFG_OFS, 32'h0000_0003);
      dev(1, PKT_LEN_OFS, 32'h0000_0004);
      dev(1, FIFO_WIN_OFS, 32'h3333_0003);
      tok(1, K_IN, 0, RESP_NAK);
      dev(1, CTRL_OFS, 32'h0000_0008);
      tok(1, K_IN, 0, RESP_DATA);
      chk(32'h0000_0004, len);
      tok(1, K_ACK, 0, RESP_NONE);
      apb(1, APB_CFG_OFS, 32'h0000_0001);
      dev(1, PKT_LEN_OFS, 32'h0000_0004);
      dev(1, FIFO_WIN_OFS, 32'h4444_0004);
      tok(1, K_IN, 0, RESP_DATA);
      tok(1, K_ACK, 0, RESP_NONE);
      dev(1, CTRL_OFS, 32'h0000_0001);
      tok(1, K_IN, 0, RESP_STALL);
      dev(1, EPTYPE_OFS, 32'h0);
      dev(1, EPTYPE_OFS, 32'h0000_0008);
      tok(3, K_IN, 0, RESP_NAK);
      dev(1, INDEX_OFS, 32'h0000_0003);
      dev(1, EPTYPE_OFS, {30'h0, EPTYPE_ISO});
      dev(1, CTRL_OFS, 32'h0000_0001);
      tok(3, K_IN, 0, RESP_NAK);
      // out endpoint 2 on a 16-bit bus, odd length
      apb(1, APB_CFG_OFS, 32'h0);
      pw(2, 0, 32'h4433_2211);
      pw(2, 1, 32'h0000_0055);
      tok(2, K_OUT, 5, RESP_ACK);
      chk(32'h0000_0001, evt);
      dev(1, INDEX_OFS, 32'h0000_0002);
      dev(0, PKT_LEN_OFS, 32'h0000_0005);
      dev(0, FIFO_WIN_OFS, 32'h0000_2211);
      dev(0, FIFO_WIN_OFS, 32'h0000_4433);
      dev(0, FIFO_WIN_OFS, 32'h0000_0055);
      dev(0, FIFO_WIN_OFS, 32'h0000_0000);
      tok(2, K_OUT, 5, RESP_ACK);
      tok(2, K_OUT, 5, RESP_NAK);
      dev(1, CTRL_OFS, 32'h0000_0010);
      tok(2, K_OUT, 5, RESP_ACK);
      // control status stage, both directions
      tok(0, K_SIN, 0, RESP_NAK);
      dev(1, INDEX_OFS, 32'h0);
      dev(1, CTRL_OFS, 32'h0000_0002);
      tok(0, K_SIN, 0, RESP_ZLP);
      tok(0, K_ACK, 0, RESP_NONE);
      dev(0, CTRL_OFS, 32'h0);
      dev(1, CTRL_OFS, 32'h0000_0002);
      tok(0, K_SOUT, 0, RESP_ACK);
      dev(0, CTRL_OFS, 32'h0);
      dev(1, INDEX_OFS, 32'h0000_0002);
      usb_bus_reset <= 1'b1;
      @(posedge pclk);
      usb_bus_reset <= 1'b0;
      @(posedge pclk);
      dev(0, PKT_LEN_OFS, 32'h0);
      give_verdict;
   end
endmodule
